/* verilog/page_irq_defines.svh */
// Purpose: offsets, reset values and field positions of the page interrupt unit
// Assumes: byte addresses on a 32-bit AXI4-Lite bus
// Notes:   definitions only
`ifndef PAGE_IRQ_DEFINES_SVH
`define PAGE_IRQ_DEFINES_SVH

`define PG_ADDR_W          8
`define PG_OFF_PEND_LOW    8'h58
`define PG_OFF_PEND_HIGH   8'h5C
`define PG_OFF_MASK_LOW    8'h60
`define PG_OFF_MASK_HIGH   8'h64

`define PG_PEND_RESET      32'h0000_0000
`define PG_MASK_RESET      32'h0FFF_FFFF

// page geometry of the lower half of the window
`define PG_PAGE_SHIFT      12
`define PG_PAGE_IDX_W      6
`define PG_PAGES           64
`define PG_VEC_W           32

`define PG_RESP_OKAY       2'b00
`define PG_RESP_SLVERR     2'b10

`endif

/* verilog/page_irq_pkg.sv */
// Purpose: types shared by the page interrupt unit
// Assumes: nothing beyond the defines header
// Notes:   carriers travel as packed structs
package page_irq_pkg;

  typedef logic [31:0] word_t;

  // one finished transfer through the upstream window
  typedef struct packed {
    logic  valid;
    logic  ok;
    word_t offset;
  } xfer_evt_t;

  typedef enum logic {
    MODE_FORWARD = 1'b0,
    MODE_REVERSE = 1'b1
  } bridge_mode_t;

  // secondary interface signalling
  typedef struct packed {
    logic inta_n;
    logic msg_assert;
    logic msg_deassert;
    logic msi_req;
  } sec_irq_t;

endpackage

/* verilog/page_vector_bank.sv */
// Purpose: one 32-page pending vector with its mask
// Assumes: set and clear vectors are one-cycle requests
// Notes:   a set in the same cycle as a clear wins
`timescale 1ns/1ps
`default_nettype none
`include "page_irq_defines.svh"
module page_vector_bank
  import page_irq_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst_n,
  input  wire word_t set_bits,
  input  wire word_t clr_pend,
  input  wire word_t clr_mask,
  output var  word_t pending,
  output var  word_t mask
);

  word_t next_pending;
  word_t next_mask;

  always_comb begin
    next_pending = (pending & ~clr_pend) | set_bits;
    next_mask    = mask & ~clr_mask;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pending <= `PG_PEND_RESET;
      mask    <= `PG_MASK_RESET;
    end else begin
      pending <= next_pending;
      mask    <= next_mask;
    end
  end

  chk_set_wins: assert property (@(posedge clock) disable iff (!rst_n)
    (set_bits != '0) |=> ((pending & $past(set_bits)) == $past(set_bits)))
    else $error("set page bit not pending");

  chk_zero_keeps: assert property (@(posedge clock) disable iff (!rst_n)
    (set_bits == '0 && clr_pend == '0) |=> (pending == $past(pending)))
    else $error("pending changed without cause");

  chk_mask_only_clears: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> ((mask & ~$past(mask)) == '0))
    else $error("mask bit rose after reset");

endmodule
`default_nettype wire

/* verilog/page_boundary_irq_unit.sv */
// Purpose: page boundary interrupt logic behind an AXI4-Lite register port
// Assumes: transfer events and mode straps synchronous to clock
// Notes:   one core clock, synchronous active-low reset
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "page_irq_defines.svh"
module page_boundary_irq_unit
  import page_irq_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // axi4-lite slave
  input  wire logic [`PG_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  input  wire word_t                 s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  output var  logic [1:0]            s_axi_bresp,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [`PG_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  output var  word_t                 s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // transfer completions and mode
  input  wire xfer_evt_t             xfer,
  input  wire bridge_mode_t          bridge_mode,
  input  wire logic                  msi_enable,
  // interrupt outputs
  output var  logic                  irq,
  output var  sec_irq_t              sec_irq
);

  // write channel state
  logic                  aw_held;
  logic [`PG_ADDR_W-1:0] aw_addr;
  logic                  w_held;
  word_t                 w_data;
  logic [3:0]            w_strb;
  logic                  next_aw_held;
  logic [`PG_ADDR_W-1:0] next_aw_addr;
  logic                  next_w_held;
  word_t                 next_w_data;
  logic [3:0]            next_w_strb;
  logic                  next_bvalid;
  logic [1:0]            next_bresp;
  // read channel state
  logic                  next_rvalid;
  word_t                 next_rdata;
  logic [1:0]            next_rresp;
  logic                  next_arready;
  // register effects
  logic                  wr_fire;
  word_t                 wr_bits;
  word_t                 clr_pend [2];
  word_t                 clr_mask [2];
  word_t                 set_bits [2];
  word_t                 pending  [2];
  word_t                 mask     [2];
  // event decode
  logic [`PG_PAGES-1:0]  page_hit;
  logic [`PG_PAGE_IDX_W-1:0] page_idx;
  logic                  in_lower_half;
  logic                  last_dword;
  logic                  evt_take;
  // interrupt state
  logic                  next_irq;
  sec_irq_t              next_sec_irq;
  logic                  irq_rise;
  logic                  irq_fall;

  // ---------------- write channel ----------------
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_bits = s_axi_wdata_mask(w_data, w_strb);

  function automatic word_t s_axi_wdata_mask(input word_t d, input logic [3:0] s);
    word_t m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return d & m;
  endfunction

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      unique case (aw_addr)
        `PG_OFF_PEND_LOW, `PG_OFF_PEND_HIGH,
        `PG_OFF_MASK_LOW, `PG_OFF_MASK_HIGH: next_bresp = `PG_RESP_OKAY;
        default:                             next_bresp = `PG_RESP_SLVERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // write-one-to-clear decode
  always_comb begin
    clr_pend[0] = '0;
    clr_pend[1] = '0;
    clr_mask[0] = '0;
    clr_mask[1] = '0;
    if (wr_fire) begin
      unique case (aw_addr)
        `PG_OFF_PEND_LOW:  clr_pend[0] = wr_bits;
        `PG_OFF_PEND_HIGH: clr_pend[1] = wr_bits;
        `PG_OFF_MASK_LOW:  clr_mask[0] = wr_bits;
        `PG_OFF_MASK_HIGH: clr_mask[1] = wr_bits;
        default: begin
          clr_pend[0] = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      w_held        <= 1'b0;
      w_data        <= '0;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PG_RESP_OKAY;
    end else begin
      aw_held       <= next_aw_held;
      aw_addr       <= next_aw_addr;
      w_held        <= next_w_held;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready  <= !next_w_held && !next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
    end
  end

  // ---------------- read channel ----------------
  always_comb begin
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    next_arready = s_axi_arready;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid  = 1'b1;
      next_arready = 1'b0;
      next_rresp   = `PG_RESP_OKAY;
      unique case (s_axi_araddr)
        `PG_OFF_PEND_LOW:  next_rdata = pending[0];
        `PG_OFF_PEND_HIGH: next_rdata = pending[1];
        `PG_OFF_MASK_LOW:  next_rdata = mask[0];
        `PG_OFF_MASK_HIGH: next_rdata = mask[1];
        default: begin
          next_rdata = '0;
          next_rresp = `PG_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `PG_RESP_OKAY;
    end else begin
      s_axi_arready <= next_arready || (!next_rvalid && !s_axi_rvalid);
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ---------------- page boundary events ----------------
  assign page_idx      = xfer.offset[`PG_PAGE_SHIFT +: `PG_PAGE_IDX_W];
  assign in_lower_half = (xfer.offset[31:`PG_PAGE_SHIFT+`PG_PAGE_IDX_W] == '0);
  assign last_dword    = &xfer.offset[`PG_PAGE_SHIFT-1:2];
  assign evt_take      = xfer.valid && xfer.ok && in_lower_half && last_dword;

  for (genvar i = 0; i < `PG_PAGES; i++) begin : g_page
    localparam logic [`PG_PAGE_IDX_W-1:0] page_num = `PG_PAGE_IDX_W'(i);
    assign page_hit[i] = evt_take && (page_idx == page_num);
  end

  assign set_bits[0] = page_hit[`PG_VEC_W-1:0];
  assign set_bits[1] = page_hit[`PG_PAGES-1:`PG_VEC_W];

  for (genvar v = 0; v < 2; v++) begin : g_vec
    page_vector_bank u_bank (
      .clock    (clock),
      .rst_n    (rst_n),
      .set_bits (set_bits[v]),
      .clr_pend (clr_pend[v]),
      .clr_mask (clr_mask[v]),
      .pending  (pending[v]),
      .mask     (mask[v])
    );
  end

  // ---------------- interrupt signalling ----------------
  always_comb begin
    next_irq = |(pending[0] & ~mask[0]) || |(pending[1] & ~mask[1]);
  end

  assign irq_rise = next_irq && !irq;
  assign irq_fall = !next_irq && irq;

  always_comb begin
    next_sec_irq              = '0;
    next_sec_irq.inta_n       = 1'b1;
    next_sec_irq.msi_req      = msi_enable && irq_rise;
    if (!msi_enable) begin
      unique case (bridge_mode)
        MODE_FORWARD: next_sec_irq.inta_n = !next_irq;
        MODE_REVERSE: begin
          next_sec_irq.msg_assert   = irq_rise;
          next_sec_irq.msg_deassert = irq_fall;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq     <= 1'b0;
      sec_irq <= '{inta_n: 1'b1, msg_assert: 1'b0, msg_deassert: 1'b0, msi_req: 1'b0};
    end else begin
      irq     <= next_irq;
      sec_irq <= next_sec_irq;
    end
  end

  // ---------------- checks ----------------
  chk_low_page_map: assert property (@(posedge clock) disable iff (!rst_n)
    (evt_take && page_idx < 6'd32)
      |=> pending[0][$past(page_idx[4:0])])
    else $error("low page event lost");

  chk_high_page_map: assert property (@(posedge clock) disable iff (!rst_n)
    (evt_take && page_idx >= 6'd32)
      |=> pending[1][$past(page_idx[4:0])])
    else $error("high page event lost");

  chk_not_last_dw: assert property (@(posedge clock) disable iff (!rst_n)
    (xfer.valid && !last_dword) |-> (page_hit == '0))
    else $error("page hit without last doubleword");

  chk_irq_follows: assert property (@(posedge clock) disable iff (!rst_n)
    ((|(pending[0] & ~mask[0])) || (|(pending[1] & ~mask[1]))) |=> irq)
    else $error("unmasked pending without request");

  chk_forward_line: assert property (@(posedge clock) disable iff (!rst_n)
    (bridge_mode == MODE_FORWARD && !msi_enable) |=> (sec_irq.inta_n == !$past(next_irq)))
    else $error("forward line does not track request");

  chk_reverse_msg: assert property (@(posedge clock) disable iff (!rst_n)
    (bridge_mode == MODE_REVERSE && !msi_enable && $rose(next_irq))
      |=> (sec_irq.msg_assert && sec_irq.inta_n))
    else $error("reverse assert message missing");

  chk_w1c_clears: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_fire && aw_addr == `PG_OFF_PEND_LOW && set_bits[0] == '0)
      |=> ((pending[0] & $past(wr_bits)) == '0))
    else $error("write one did not clear pending");

  chk_masked_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    ((pending[0] | pending[1]) != '0 && (pending[0] & ~mask[0]) == '0
      && (pending[1] & ~mask[1]) == '0) |=> !irq)
    else $error("request while pending bits masked");

  chk_irq_drops: assert property (@(posedge clock) disable iff (!rst_n)
    (!(|(pending[0] & ~mask[0])) && !(|(pending[1] & ~mask[1])))
      |=> (!irq && !sec_irq.msi_req))
    else $error("request held with nothing unmasked");

  chk_fail_ignored: assert property (@(posedge clock) disable iff (!rst_n)
    (xfer.valid && !xfer.ok) |-> (page_hit == '0))
    else $error("page hit from failed transfer");

  chk_upper_ignored: assert property (@(posedge clock) disable iff (!rst_n)
    (xfer.valid && !in_lower_half) |-> (page_hit == '0))
    else $error("page hit outside lower half");

  chk_mask_w1c: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_fire && aw_addr == `PG_OFF_MASK_LOW)
      |=> ((mask[0] & $past(wr_bits)) == '0))
    else $error("write one did not clear mask");

  chk_msi_single: assert property (@(posedge clock) disable iff (!rst_n)
    sec_irq.msi_req |=> !sec_irq.msi_req)
    else $error("msi request longer than one cycle");

  chk_line_idle: assert property (@(posedge clock) disable iff (!rst_n)
    (bridge_mode == MODE_REVERSE || msi_enable) |=> sec_irq.inta_n)
    else $error("interrupt line driven outside forward line mode");

  chk_rdata_holds: assert property (@(posedge clock) disable iff (!rst_n)
    (s_axi_rvalid && !s_axi_rready)
      |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
    else $error("read data changed before taken");

  chk_bresp_once: assert property (@(posedge clock) disable iff (!rst_n)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response dropped early");

endmodule
`default_nettype wire

/* dv/sec_irq_host.sv */
// Purpose: host on the secondary interrupt interface
// Assumes: message and msi pulses last one clock
// Notes:   counts arrivals for the bench
`timescale 1ns/1ps
`default_nettype none
module sec_irq_host
  import page_irq_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire sec_irq_t   sec_irq,
  output var  logic [7:0] msi_seen,
  output var  logic [7:0] asserts_seen,
  output var  logic [7:0] deasserts_seen
);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      msi_seen       <= 8'h00;
      asserts_seen   <= 8'h00;
      deasserts_seen <= 8'h00;
    end else begin
      if (sec_irq.msi_req) msi_seen <= msi_seen + 8'h01;
      if (sec_irq.msg_assert) asserts_seen <= asserts_seen + 8'h01;
      if (sec_irq.msg_deassert) deasserts_seen <= deasserts_seen + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* dv/page_boundary_irq_unit_test.sv */
// Purpose: self-checking bench for the page boundary interrupt unit
// Assumes: AXI4-Lite master tasks, events as one-cycle pulses
// Notes:   mode loop covers every signalling choice
`timescale 1ns/1ps
`default_nettype none
`include "page_irq_defines.svh"
module page_boundary_irq_unit_test
  import page_irq_pkg::*;
  ;
  logic                  clock, rst_n, msi_enable, irq;
  logic [`PG_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                  s_axi_rvalid, s_axi_rready;
  word_t                 s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp, rsp;
  logic [23:0]           cnt;
  xfer_evt_t             xfer;
  bridge_mode_t          bridge_mode;
  sec_irq_t              sec_irq;
  logic [7:0]            msi_seen, asserts_seen, deasserts_seen;
  int                    num_errors, comparisons;

  page_boundary_irq_unit dut (
    .clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .xfer, .bridge_mode, .msi_enable, .irq, .sec_irq
  );
  sec_irq_host host (.clock, .rst_n, .sec_irq, .msi_seen, .asserts_seen, .deasserts_seen);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input word_t seen, input word_t exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stalled();
    num_errors++;
    $display("[ERR] handshake expected answer seen none");
    summarize();
  endtask

  task automatic axi_write(input logic [7:0] a, input word_t d, input logic [3:0] s);
    bit done;
    done = 1'b0;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) stalled();
  endtask

  task automatic axi_read(input logic [7:0] a);
    bit done;
    done = 1'b0;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) stalled();
  endtask

  task automatic expect_reg(input logic [7:0] a, input word_t exp);
    axi_read(a);
    check("register read", rd, exp);
    check("read response", rsp, `PG_RESP_OKAY);
  endtask

  // back-to-back completions, then idle until the outputs settle
  task automatic events(input word_t offs[$], input logic ok);
    foreach (offs[i]) begin
      @(posedge clock);
      xfer <= '{valid: 1'b1, ok: ok, offset: offs[i]};
    end
    @(posedge clock);
    xfer.valid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, msi_enable} = '0;
    xfer = '0;
    bridge_mode = MODE_FORWARD;
    num_errors = 0;
    comparisons = 0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    expect_reg(`PG_OFF_PEND_LOW, 32'h0000_0000);
    expect_reg(`PG_OFF_PEND_HIGH, 32'h0000_0000);
    expect_reg(`PG_OFF_MASK_LOW, 32'h0FFF_FFFF);
    expect_reg(`PG_OFF_MASK_HIGH, 32'h0FFF_FFFF);
    axi_read(8'h68);
    check("unmapped read data", rd, 32'h0000_0000);
    check("unmapped read resp", rsp, `PG_RESP_SLVERR);
    check("irq after reset", irq, 1'b0);
    check("inta_n after reset", sec_irq.inta_n, 1'b1);
    $display("test reset_values done");
    events('{32'h0000_0FFC}, 1'b1);
    check("irq masked page", irq, 1'b0);
    events('{32'h0001_FFFC, 32'h0002_0FFC, 32'h0003_FFFC, 32'h0000_1FF8, 32'h0004_1FFC}, 1'b1);
    events('{32'h0000_2FFC}, 1'b0);
    expect_reg(`PG_OFF_PEND_LOW, 32'h8000_0001);
    expect_reg(`PG_OFF_PEND_HIGH, 32'h8000_0001);
    check("irq unmasked page", irq, 1'b1);
    check("inta_n asserted", sec_irq.inta_n, 1'b0);
    $display("test page_events done");
    axi_write(`PG_OFF_PEND_LOW, 32'hFFFF_FFFF, 4'h8);
    check("write response", rsp, `PG_RESP_OKAY);
    axi_write(`PG_OFF_PEND_HIGH, 32'h0000_0000, 4'hF);
    expect_reg(`PG_OFF_PEND_LOW, 32'h0000_0001);
    expect_reg(`PG_OFF_PEND_HIGH, 32'h8000_0001);
    check("irq high vector", irq, 1'b1);
    axi_write(`PG_OFF_PEND_HIGH, 32'h8000_0000, 4'hF);
    repeat (3) @(posedge clock);
    check("irq all masked", irq, 1'b0);
    check("inta_n released", sec_irq.inta_n, 1'b1);
    axi_write(8'h68, 32'hFFFF_FFFF, 4'hF);
    check("unmapped write resp", rsp, `PG_RESP_SLVERR);
    expect_reg(`PG_OFF_MASK_LOW, 32'h0FFF_FFFF);
    axi_write(`PG_OFF_MASK_LOW, 32'h0000_0001, 4'hF);
    expect_reg(`PG_OFF_MASK_LOW, 32'h0FFF_FFFE);
    check("irq unmasked bit", irq, 1'b1);
    axi_write(`PG_OFF_PEND_LOW, 32'h0000_0001, 4'hF);
    $display("test clear_and_mask done");
    // bit 1 of m selects reverse mode, bit 0 selects msi
    for (int m = 0; m < 4; m++) begin
      bridge_mode <= bridge_mode_t'(m[1]);
      msi_enable  <= m[0];
      repeat (3) @(posedge clock);
      cnt = {msi_seen, asserts_seen, deasserts_seen};
      events('{32'h0000_0FFC}, 1'b1);
      check("inta_n on request", sec_irq.inta_n, m != 0);
      check("msi pulses", msi_seen - cnt[23:16], m[0]);
      check("assert messages", asserts_seen - cnt[15:8], m == 2);
      axi_write(`PG_OFF_PEND_LOW, 32'h0000_0001, 4'hF);
      repeat (3) @(posedge clock);
      check("deassert messages", deasserts_seen - cnt[7:0], m == 2);
      check("inta_n idle", sec_irq.inta_n, 1'b1);
      check("irq cleared", irq, 1'b0);
    end
    $display("test signalling_modes done");
    summarize();
  end
endmodule
`default_nettype wire
